// [hw/rbu_pkg.sv]
// Package with opcodes, cycle counts and widths of the relative branch unit
package rbu_pkg;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
	localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
	localparam logic [7:0] OP_BRANCH_UNSIGNED_LOWER_SAME = 8'h23;
	localparam logic [7:0] OP_BRANCH_IF_NOT_EQUAL = 8'h26;
	localparam logic [7:0] OP_BRANCH_IF_POSITIVE = 8'h2A;
	localparam logic [7:0] OP_BRANCH_IF_NEGATIVE = 8'h2B;
	localparam logic [7:0] OP_BRANCH_IF_MASK_SET = 8'h2D;
	localparam logic [7:0] OP_BRANCH_SIGNED_LESS = 8'h91;
	localparam logic [7:0] OP_BIT_CLEAR_FIRST = 8'h01;
	localparam logic [7:0] OP_BIT_CLEAR_LAST = 8'h0F;
	// ==========================================================
	// Instruction lengths and cycle counts
	localparam logic [15:0] REL_LEN = 16'h0002;
	localparam logic [15:0] BIT_LEN = 16'h0003;
	localparam logic [2:0] REL_CYCLES = 3'h3;
	localparam logic [2:0] BIT_CYCLES = 3'h5;
	// ==========================================================
	// Flag positions in the condition flags byte
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_I = 3;
	localparam int FLAG_V = 7;
	// ==========================================================
	// Reset values and direct-page high byte
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] DIRECT_PAGE_HIGH = 8'h00;
	typedef enum logic [2:0] {
		RBU_IDLE,
		RBU_FETCH_ADDR,
		RBU_READ_MEM,
		RBU_FETCH_REL,
		RBU_WAIT,
		RBU_DONE
	} rbu_state_t;
endpackage : rbu_pkg

// [hw/rbu_cond_eval.sv]
// Branch condition evaluator for flag and bit-test branches
`timescale 1ns/100ps
module rbu_cond_eval (
	input wire logic [7:0] opcode,
	input wire logic [7:0] flags,
	input wire logic [7:0] memByte,
	output logic takeBranch,
	output logic isBitTest,
	output logic isKnown
);
	logic testedBit;
	// ==========================================================
	// Bit-test opcodes are odd and sit in 01..0F; bit n is opcode[3:1]
	assign isBitTest = (opcode >= rbu_pkg::OP_BIT_CLEAR_FIRST) &&
		(opcode <= rbu_pkg::OP_BIT_CLEAR_LAST) && opcode[0]; // RULE7
	assign testedBit = memByte[opcode[3:1]]; // RULE7
	// Condition per opcode; unknown opcodes never branch
	always_comb begin
		takeBranch = 1'b0;
		isKnown = 1'b1;
		if (isBitTest) begin
			takeBranch = ~testedBit; // RULE7
		end else begin
			case (opcode)
				rbu_pkg::OP_BRANCH_IF_NEGATIVE: takeBranch = flags[rbu_pkg::FLAG_N]; // RULE1
				rbu_pkg::OP_BRANCH_IF_POSITIVE: takeBranch = ~flags[rbu_pkg::FLAG_N]; // RULE2
				rbu_pkg::OP_BRANCH_IF_MASK_SET: takeBranch = flags[rbu_pkg::FLAG_I]; // RULE3
				rbu_pkg::OP_BRANCH_IF_NOT_EQUAL: takeBranch = ~flags[rbu_pkg::FLAG_Z]; // RULE4
				rbu_pkg::OP_BRANCH_ALWAYS: takeBranch = 1'b1; // RULE5
				rbu_pkg::OP_BRANCH_NEVER: takeBranch = 1'b0; // RULE6
				rbu_pkg::OP_BRANCH_SIGNED_LESS: takeBranch =
					flags[rbu_pkg::FLAG_N] ^ flags[rbu_pkg::FLAG_V]; // RULE10
				rbu_pkg::OP_BRANCH_UNSIGNED_LOWER_SAME: takeBranch =
					flags[rbu_pkg::FLAG_C] | flags[rbu_pkg::FLAG_Z]; // RULE11
				default: isKnown = 1'b0;
			endcase
		end
	end
endmodule : rbu_cond_eval

// [hw/rbu_relative_branch_unit.sv]
// Relative branch execution unit: sequencing, target calculation, flag update
// ==========================================================
// Functional notes
// (RULE1) Negative-flag branch taken when N is 1; 3 cycles; flags kept.
// (RULE2) Positive branch taken when N is 0; 3 cycles; flags kept.
// (RULE3) Mask-set branch taken when I is 1; 3 cycles; flags kept.
// (RULE4) Not-equal branch taken when Z is 0; 3 cycles; flags kept.
// (RULE5) Branch always: PC becomes opcode address plus two plus signed displacement.
// (RULE6) Branch never: two-byte no-operation, 3 cycles, flags kept.
// (RULE7) Bit-clear branch tests bit n, opcode 2n+1, target plus three, 5 cycles.
// (RULE8) Bit-test operand address is one direct-page byte, 0000 to 00FF.
// (RULE9) Bit-test branch copies tested bit into carry; other flags kept.
// (RULE10) Signed less branch taken when N xor V is 1.
// (RULE11) Unsigned lower-or-same branch taken when C or Z is 1.
// (RULE12) Untaken branch advances PC past whole instruction, two or three bytes.
`timescale 1ns/100ps
module rbu_relative_branch_unit (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [15:0] opcodeAddr,
	input wire logic [7:0] flagsIn,
	input wire logic [7:0] memRdata,
	output logic [15:0] memAddr,
	output logic memRd,
	output logic busy,
	output logic done,
	output logic branchTaken,
	output logic illegalOp,
	output logic [15:0] pcOut,
	output logic [7:0] flagsOut,
	output logic [2:0] cycleCount
);
	rbu_pkg::rbu_state_t state_ff, nxt_state;
	logic [7:0] op_ff;
	logic [15:0] base_ff;
	logic [7:0] flags_ff;
	logic [7:0] memByte_ff;
	logic [15:0] memAddr_ff;
	logic memRd_ff;
	logic [2:0] cyc_ff;
	logic [2:0] target_ff;
	logic [15:0] pc_ff;
	logic taken_ff;
	logic done_ff;
	logic illegal_ff;
	logic [7:0] flagsOut_ff;
	logic [2:0] cycleCount_ff;
	logic take;
	logic isBit;
	logic known;
	logic [15:0] seqPc;
	logic [15:0] relExt;

	// ==========================================================
	// Condition evaluation
	rbu_cond_eval u_cond (
		.opcode(op_ff),
		.flags(flags_ff),
		.memByte(memByte_ff),
		.takeBranch(take),
		.isBitTest(isBit),
		.isKnown(known)
	);

	// Sequential address past the instruction, and signed displacement
	assign seqPc = base_ff + (isBit ? rbu_pkg::BIT_LEN : rbu_pkg::REL_LEN); // RULE12
	assign relExt = {{8{memRdata[7]}}, memRdata}; // RULE5

	// ==========================================================
	// Next-state logic; one memory access per cycle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			rbu_pkg::RBU_IDLE: if (start) nxt_state = rbu_pkg::RBU_FETCH_ADDR;
			rbu_pkg::RBU_FETCH_ADDR: nxt_state = isBit ? rbu_pkg::RBU_READ_MEM
				: rbu_pkg::RBU_FETCH_REL;
			rbu_pkg::RBU_READ_MEM: nxt_state = rbu_pkg::RBU_FETCH_REL;
			rbu_pkg::RBU_FETCH_REL: nxt_state = (cyc_ff + 3'h1 >= target_ff) ?
				rbu_pkg::RBU_DONE : rbu_pkg::RBU_WAIT;
			rbu_pkg::RBU_WAIT: if (cyc_ff + 3'h1 >= target_ff) nxt_state = rbu_pkg::RBU_DONE;
			rbu_pkg::RBU_DONE: nxt_state = rbu_pkg::RBU_IDLE;
			default: nxt_state = rbu_pkg::RBU_IDLE;
		endcase
	end

	// Bit-test opcodes are the odd values 01..0F; needed before op_ff is loaded
	function automatic logic isBitOpcode(input logic [7:0] op);
		return (op >= rbu_pkg::OP_BIT_CLEAR_FIRST) &&
			(op <= rbu_pkg::OP_BIT_CLEAR_LAST) && op[0];
	endfunction : isBitOpcode

	// ==========================================================
	// Bus request for the coming state, registered so that address and strobe
	// leave flip-flops; flag branches skip the address fetch
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			memAddr_ff <= 16'h0000;
			memRd_ff <= 1'b0;
		end else begin
			case (nxt_state)
				rbu_pkg::RBU_FETCH_ADDR: begin
					// Context still on the inputs, not yet in op_ff and base_ff
					memAddr_ff <= opcodeAddr + 16'h0001;
					memRd_ff <= isBitOpcode(opcode); // RULE7
				end
				rbu_pkg::RBU_READ_MEM: begin
					// Direct address byte stands on the read data in this cycle
					memAddr_ff <= {rbu_pkg::DIRECT_PAGE_HIGH, memRdata}; // RULE8
					memRd_ff <= 1'b1;
				end
				rbu_pkg::RBU_FETCH_REL: begin
					memAddr_ff <= base_ff + (isBit ? 16'h0002 : 16'h0001);
					memRd_ff <= 1'b1;
				end
				default: begin
					memAddr_ff <= 16'h0000;
					memRd_ff <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk) begin
		if (!reset_n) state_ff <= rbu_pkg::RBU_IDLE;
		else state_ff <= nxt_state;
	end

	// Capture the instruction context on start
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			op_ff <= 8'h00;
			base_ff <= rbu_pkg::PC_RESET;
			flags_ff <= rbu_pkg::FLAGS_RESET;
		end else if (state_ff == rbu_pkg::RBU_IDLE && start) begin
			op_ff <= opcode;
			base_ff <= opcodeAddr;
			flags_ff <= flagsIn;
		end
	end

	// Cycle counter; the cycle after the start cycle counts as the first cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cyc_ff <= 3'h0;
			target_ff <= rbu_pkg::REL_CYCLES;
		end else if (state_ff == rbu_pkg::RBU_IDLE) begin
			cyc_ff <= 3'h1;
		end else begin
			cyc_ff <= cyc_ff + 3'h1;
			if (state_ff == rbu_pkg::RBU_FETCH_ADDR)
				target_ff <= isBit ? rbu_pkg::BIT_CYCLES : rbu_pkg::REL_CYCLES; // RULE7
		end
	end

	// Memory operand, read from the direct page
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			memByte_ff <= 8'h00;
		end else if (state_ff == rbu_pkg::RBU_READ_MEM) begin
			memByte_ff <= memRdata; // RULE8
		end
	end

	// ==========================================================
	// Target or fall-through; result held until the next instruction
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pc_ff <= rbu_pkg::PC_RESET;
		end else if (state_ff == rbu_pkg::RBU_FETCH_REL) begin
			if (take & known) pc_ff <= seqPc + relExt; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE7
			else pc_ff <= seqPc; // RULE6 RULE12
		end
	end

	// Outcome; an unknown opcode is reported and never branches
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			taken_ff <= 1'b0;
			illegal_ff <= 1'b0;
		end else if (state_ff == rbu_pkg::RBU_FETCH_REL) begin
			taken_ff <= take & known;
			illegal_ff <= ~known;
		end
	end

	// Flags pass through; only a bit test writes carry
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			flagsOut_ff <= rbu_pkg::FLAGS_RESET;
		end else if (state_ff == rbu_pkg::RBU_FETCH_REL) begin
			flagsOut_ff <= flags_ff; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
			if (isBit) begin
				flagsOut_ff[rbu_pkg::FLAG_C] <= memByte_ff[op_ff[3:1]]; // RULE9
			end
		end
	end

	// Done pulse in the last counted cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (nxt_state == rbu_pkg::RBU_DONE);
		end
	end

	// Cycle count report, held with the other results
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cycleCount_ff <= 3'h0;
		end else if (nxt_state == rbu_pkg::RBU_DONE) begin
			cycleCount_ff <= target_ff; // RULE1 RULE7
		end
	end

	assign memAddr = memAddr_ff;
	assign memRd = memRd_ff;
	assign busy = (state_ff != rbu_pkg::RBU_IDLE);
	assign done = done_ff;
	assign branchTaken = taken_ff;
	assign illegalOp = illegal_ff;
	assign pcOut = pc_ff;
	assign flagsOut = flagsOut_ff;
	assign cycleCount = cycleCount_ff;
endmodule : rbu_relative_branch_unit

// [tb/rbu_mem_model.sv]
// Byte memory that answers the unit's read strobe in the same cycle
`timescale 1ns/100ps
module rbu_mem_model (
	input wire logic mclk,
	input wire logic memRd,
	input wire logic [15:0] memAddr,
	output logic [7:0] memRdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastFf = 8'hA5;
	// ==========
	// Idle bus shows the inverse of the last byte so stale data never matches
	assign memRdata = memRd ? mem[memAddr] : ~lastFf;
	// Last byte read
	always_ff @(posedge mclk) begin
		if (memRd) begin
			lastFf <= mem[memAddr];
		end
	end
endmodule : rbu_mem_model

// [tb/rbu_chk.sv]
// Port checker for the relative branch unit
`timescale 1ns/100ps
module rbu_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] flagsIn,
	input wire logic [15:0] memAddr,
	input wire logic memRd,
	input wire logic busy,
	input wire logic done,
	input wire logic branchTaken,
	input wire logic illegalOp,
	input wire logic [15:0] pcOut,
	input wire logic [7:0] flagsOut,
	input wire logic [2:0] cycleCount,
	input wire logic [15:0] opcodeAddr
);
	logic accept, isBit, isFlag, bitFf;
	logic [15:0] addrFf;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Decode of the accepted request
	assign accept = start && !busy;
	assign isBit = opcode[0] && opcode[7:4] == 4'h0;
	assign isFlag = opcode inside {8'h20, 8'h21, 8'h23, 8'h26, 8'h2A, 8'h2B, 8'h2D, 8'h91};
	// Held until completion, as a new start is refused meanwhile
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bitFf <= 1'b0;
			addrFf <= 16'h0000;
		end else if (accept) begin
			bitFf <= isBit;
			addrFf <= opcodeAddr;
		end
	end
	// ==========
	// Checks
	AST_FLAG_LAT: assert property (accept && isFlag |-> ##3 done)
		else $error("flag branch latency wrong");
	AST_BIT_LAT: assert property (accept && isBit |-> ##5 done)
		else $error("bit branch latency wrong");
	AST_FLAG_KEEP: assert property (accept && isFlag |-> ##3 flagsOut == $past(flagsIn, 3))
		else $error("flag branch altered flags");
	AST_CARRY: assert property (accept && isBit |-> ##5 flagsOut[0] == !branchTaken
		&& (flagsOut >> 1) == ($past(flagsIn, 5) >> 1)) else $error("carry copy wrong");
	AST_DP: assert property (accept && isBit |-> ##2 memRd && memAddr[15:8] == 8'h00)
		else $error("operand outside direct page");
	AST_NEVER: assert property (accept && opcode == 8'h21 |-> ##3 !branchTaken)
		else $error("branch never was taken");
	AST_UNTAKEN: assert property (done && !branchTaken |->
		pcOut == addrFf + (bitFf ? 16'h0003 : 16'h0002)) else $error("untaken pc wrong");
	AST_CYC: assert property (done && !illegalOp |-> cycleCount == (bitFf ? 3'h5 : 3'h3))
		else $error("cycle count wrong");
endmodule : rbu_chk
bind rbu_relative_branch_unit rbu_chk i_chk (.mclk, .reset_n, .start, .opcode, .flagsIn,
	.memAddr, .memRd, .busy, .done, .branchTaken, .illegalOp, .pcOut, .flagsOut,
	.cycleCount, .opcodeAddr);

// [tb/tb_top.sv]
// Self-checking bench for the relative branch unit
`timescale 1ns/100ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
	logic mclk = 1'b0, reset_n = 1'b0, start = 1'b0;
	logic [7:0] opcode = 8'h00, flagsIn = 8'h00, memRdata, flagsOut;
	logic [15:0] opcodeAddr = 16'h0000, memAddr, pcOut;
	logic memRd, busy, done, branchTaken, illegalOp;
	logic [2:0] cycleCount;
	int fails = 0, numChecks = 0;
	logic [7:0] flagOps [8] = '{8'h2B, 8'h2A, 8'h2D, 8'h26, 8'h20, 8'h21, 8'h23, 8'h91};
	rbu_relative_branch_unit i_dut (.mclk, .reset_n, .start, .opcode, .opcodeAddr, .flagsIn,
		.memRdata, .memAddr, .memRd, .busy, .done, .branchTaken, .illegalOp, .pcOut,
		.flagsOut, .cycleCount);
	rbu_mem_model i_mem (.mclk, .memRd, .memAddr, .memRdata);
	initial forever #5 mclk = ~mclk;
	// ==========
	// Expectations
	function automatic logic [7:0] opOf(int i);
		return i < 8 ? flagOps[i] : 8'(2 * i - 15);
	endfunction : opOf
	function automatic logic expTake(logic [7:0] op, f, m);
		case (op)
			8'h2B: return f[2];
			8'h2A: return !f[2];
			8'h2D: return f[3];
			8'h26: return !f[1];
			8'h20: return 1'b1;
			8'h21: return 1'b0;
			8'h23: return f[0] | f[1];
			8'h91: return f[2] ^ f[7];
			default: return !m[op[3:1]];
		endcase
	endfunction : expTake
	task automatic end_sim();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	// One instruction; poke repeats start while busy, which must be ignored
	task automatic run(logic [7:0] op, f, m, r, d, logic [15:0] a, logic poke);
		logic bitOp, ill, tk;
		logic [15:0] len;
		bitOp = op[0] && op[7:4] == 4'h0;
		ill = op == 8'h22;
		len = bitOp ? 16'h0003 : 16'h0002;
		tk = !ill && expTake(op, f, m);
		i_mem.mem[a + 16'h0001] = bitOp ? d : r;
		i_mem.mem[a + 16'h0002] = r;
		i_mem.mem[{8'h00, d}] = m;
		@(posedge mclk);
		start <= 1'b1;
		opcode <= op;
		flagsIn <= f;
		opcodeAddr <= a;
		@(posedge mclk);
		start <= poke;
		opcode <= 8'h20;
		flagsIn <= ~f;
		@(posedge mclk);
		start <= 1'b0;
		for (int k = 0; k < 12 && done !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		if (done !== 1'b1) begin
			fails++;
			end_sim();
		end
		`CHK("taken", tk, branchTaken)
		`CHK("pc", a + len + (tk ? {{8{r[7]}}, r} : 16'h0000), pcOut)
		`CHK("flags", bitOp ? {f[7:1], m[op[3:1]]} : f, flagsOut)
		if (!ill) `CHK("cycles", bitOp ? 3'h5 : 3'h3, cycleCount)
		`CHK("illegal", ill, illegalOp)
		$display("test op %h at %h done", op, a);
	endtask : run
	// Corners first, then random traffic
	initial begin
		void'($urandom(32'h3AB4));
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			run(opOf(i), 8'hFF, 8'h00, 8'h80, 8'hFF, 16'hFFF0, 1'b0);
			run(opOf(i), 8'h00, 8'hFF, 8'h7F, 8'h00, 16'h4000, i == 3 || i == 12);
		end
		run(8'h22, 8'h5A, 8'h00, 8'h10, 8'h20, 16'h1234, 1'b0);
		repeat (80) run(opOf($urandom_range(15)), 8'($urandom), 8'($urandom), 8'($urandom),
			8'($urandom), {8'($urandom_range(254, 1)), 8'($urandom)}, 1'b0);
		end_sim();
	end
endmodule : tb_top
